// >>> rtl/fwa_config_bank.sv
// field-weakening and slow-acceleration configuration register with AXI4-Lite access
`include "fwa_defs.svh"
`default_nettype none
module fwa_config_bank
  import fwa_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // axi4-lite write address and data
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // motor-control status pins, asynchronous
  input wire logic [1:0] CTRL_MODE,
  input wire logic LIMIT_ACTIVE,
  // decoded configuration to the control loops
  output fwa_gain_t GAINS,
  output logic FW_ENABLE,
  output logic [10:0] SLOW_ACCEL_RATE,
  output logic SLOW_ACCEL_VALID,
  output logic ALIGN_ACCEL_ACTIVE,
  output logic LIMIT_RAMP_ACTIVE,
  output fwa_mode_t RATE_UNIT
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  fwa_mode_t mode_s;
  logic lim_s;

  // two stages; only sync_b is read by logic
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {LIMIT_ACTIVE, CTRL_MODE};
      sync_b <= sync_a;
    end
  end
  assign mode_s = fwa_mode_t'(sync_b[1:0]);
  assign lim_s = sync_b[2];

  // ----------------------------------------------------------------
  // axi4-lite slave and register storage
  // ----------------------------------------------------------------
  fwa_cfg_t cfg, next_cfg;
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [9:0] aw_idx, next_aw_idx;
  logic [31:0] wdata, next_wdata;
  logic [3:0] wstrb, next_wstrb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [31:0] merged;
  logic [9:0] ar_idx;
  logic [31:0] status_word;

  assign S_AXI_AWREADY = !aw_held && !bvalid;
  assign S_AXI_WREADY = !w_held && !bvalid;
  assign S_AXI_ARREADY = !rvalid;
  assign ar_idx = S_AXI_ARADDR[11:2];
  // live block state for software: mode, limit, code validity
  assign status_word = {28'h0000000, SLOW_ACCEL_VALID, lim_s, mode_s};

  // one write and one read in flight; response only after both halves
  always_comb begin
    next_cfg = cfg;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_idx = aw_idx;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    merged = cfg;
    for (int i = 0; i < 4; i++) begin
      if (wstrb[i]) begin
        merged[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_idx = S_AXI_AWADDR[11:2];
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_held = 1'b1;
      next_wdata = S_AXI_WDATA;
      next_wstrb = S_AXI_WSTRB;
    end
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (aw_idx == `FWA_IDX_ALGO2) begin
        // all fields writable, low bits out of scope
        next_cfg = fwa_cfg_t'(merged & `FWA_ALGO2_MASK);
        next_bresp = `FWA_RESP_OKAY;
      end else if (aw_idx == `FWA_IDX_STATUS) begin
        next_bresp = `FWA_RESP_OKAY; // status is read-only, write dropped
      end else begin
        next_bresp = `FWA_RESP_SLVERR;
      end
    end
    if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp = `FWA_RESP_OKAY;
      if (ar_idx == `FWA_IDX_ALGO2) begin
        next_rdata = cfg;
      end else if (ar_idx == `FWA_IDX_STATUS) begin
        next_rdata = status_word;
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = `FWA_RESP_SLVERR;
      end
    end else if (rvalid && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
  end

  // register and bus state cleared on reset
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg <= fwa_cfg_t'(`FWA_ALGO2_RST);
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_idx <= 10'h000;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_idx <= next_aw_idx;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = rdata;

  // ----------------------------------------------------------------
  // decoders
  // ----------------------------------------------------------------
  fwa_gain_t next_gains;
  logic [10:0] next_rate;
  logic next_rate_valid;
  logic [7:0] kp_m, ki_m;

  assign kp_m = cfg.fw_prop_gain[7:0];
  assign ki_m = cfg.current_loop_int_gain[7:0];

  // scaled integers keep the decimal exponent exact, no fractions
  always_comb begin
    case (cfg.fw_prop_gain[9:8])
      2'h0: next_gains.kp_x10k = 18'(kp_m) * 18'h003E8;
      2'h1: next_gains.kp_x10k = 18'(kp_m) * 18'h00064;
      2'h2: next_gains.kp_x10k = 18'(kp_m) * 18'h0000A;
      default: next_gains.kp_x10k = 18'(kp_m);
    endcase
    case (cfg.current_loop_int_gain[9:8])
      2'h0: next_gains.ki_x1k = 22'(ki_m) * 22'h002710;
      2'h1: next_gains.ki_x1k = 22'(ki_m) * 22'h0003E8;
      2'h2: next_gains.ki_x1k = 22'(ki_m) * 22'h000064;
      default: next_gains.ki_x1k = 22'(ki_m) * 22'h00000A;
    endcase
    // rate in tenths of the mode's unit per second
    next_rate_valid = 1'b1;
    case (cfg.closed_loop_slow_accel)
      4'h0: next_rate = 11'h001;
      4'h1: next_rate = 11'h00A;
      4'h2: next_rate = 11'h014;
      4'h3: next_rate = 11'h01E;
      4'h4: next_rate = 11'h032;
      4'h5: next_rate = 11'h064;
      4'h6: next_rate = 11'h0C8;
      4'h7: next_rate = 11'h12C;
      4'h8: next_rate = 11'h190;
      4'h9: next_rate = 11'h1F4;
      4'hA: next_rate = 11'h3E8;
      default: begin
        next_rate = 11'h000; // codes above A are not decoded here
        next_rate_valid = 1'b0;
      end
    endcase
  end

  // decoded outputs come from flops, one cycle behind the register or the pin synchronisers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      GAINS <= '0;
      FW_ENABLE <= 1'b0;
      SLOW_ACCEL_RATE <= 11'h000;
      SLOW_ACCEL_VALID <= 1'b0;
      ALIGN_ACCEL_ACTIVE <= 1'b0;
      LIMIT_RAMP_ACTIVE <= 1'b0;
      RATE_UNIT <= FWA_SPEED;
    end else begin
      GAINS <= next_gains;
      FW_ENABLE <= cfg.fw_enable;
      SLOW_ACCEL_RATE <= next_rate;
      SLOW_ACCEL_VALID <= next_rate_valid;
      // alignment use only in speed mode
      ALIGN_ACCEL_ACTIVE <= (mode_s == FWA_SPEED);
      LIMIT_RAMP_ACTIVE <= lim_s;
      RATE_UNIT <= mode_s;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_kp_exp3;
    @(posedge CLK) disable iff (SYS_RST)
      (cfg.fw_prop_gain[9:8] == 2'h3) |=> (GAINS.kp_x10k == 18'($past(kp_m)));
  endproperty
  a_kp_exp3: assert property (p_kp_exp3) else $error("kp decode wrong at exponent 3");

  property p_ki_exp0;
    @(posedge CLK) disable iff (SYS_RST)
      (cfg.current_loop_int_gain[9:8] == 2'h0)
        |=> (GAINS.ki_x1k == 22'($past(ki_m)) * 22'h002710);
  endproperty
  a_ki_exp0: assert property (p_ki_exp0) else $error("ki decode wrong at exponent 0");

  property p_fw_en;
    @(posedge CLK) disable iff (SYS_RST)
      $rose(cfg.fw_enable) |=> FW_ENABLE;
  endproperty
  a_fw_en: assert property (p_fw_en) else $error("field weakening enable not applied");

  property p_reset_zero;
    @(posedge CLK) SYS_RST |=> (cfg == '0) && !FW_ENABLE && !S_AXI_BVALID;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

  property p_write_lands;
    @(posedge CLK) disable iff (SYS_RST)
      (aw_held && w_held && !bvalid && aw_idx == `FWA_IDX_ALGO2 && wstrb == 4'hF)
        |=> (cfg == ($past(wdata) & `FWA_ALGO2_MASK)) && S_AXI_BVALID;
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write did not land");

  property p_code0_rate;
    @(posedge CLK) disable iff (SYS_RST)
      (cfg.closed_loop_slow_accel == 4'h0) |=> (SLOW_ACCEL_RATE == 11'h001) && SLOW_ACCEL_VALID;
  endproperty
  a_code0_rate: assert property (p_code0_rate) else $error("code 0 rate wrong");

  property p_speed_align;
    @(posedge CLK) disable iff (SYS_RST)
      (mode_s != FWA_SPEED) |=> !ALIGN_ACCEL_ACTIVE;
  endproperty
  a_speed_align: assert property (p_speed_align) else $error("alignment in wrong mode");

  property p_limit_ramp;
    @(posedge CLK) disable iff (SYS_RST)
      lim_s ##1 lim_s |-> LIMIT_RAMP_ACTIVE && (RATE_UNIT == $past(mode_s));
  endproperty
  a_limit_ramp: assert property (p_limit_ramp) else $error("limit ramp not flagged");

  property p_unit_mode;
    @(posedge CLK) disable iff (SYS_RST)
      (mode_s == FWA_TORQUE) |=> (RATE_UNIT == FWA_TORQUE);
  endproperty
  a_unit_mode: assert property (p_unit_mode) else $error("rate unit not following mode");

  property p_ki_by_write;
    @(posedge CLK) disable iff (SYS_RST)
      $changed(cfg.current_loop_int_gain)
        |-> $past(aw_held && w_held && aw_idx == `FWA_IDX_ALGO2);
  endproperty
  a_ki_by_write: assert property (p_ki_by_write) else $error("ki changed without a write");

endmodule // fwa_config_bank
`default_nettype wire

// >>> rtl/fwa_defs.svh
// offsets, field positions, reset values and codes for the field-weakening config bank
`ifndef FWA_DEFS_SVH
`define FWA_DEFS_SVH
`define FWA_IDX_ALGO2 10'h0A2
`define FWA_IDX_STATUS 10'h0A3
`define FWA_ALGO2_RST 32'h0000_0000
`define FWA_ALGO2_MASK 32'hFFFF_FFC0
`define FWA_PARITY_BIT 31
`define FWA_KP_HI 30
`define FWA_KP_LO 21
`define FWA_KI_HI 20
`define FWA_KI_LO 11
`define FWA_FW_EN_BIT 10
`define FWA_SLOW_HI 9
`define FWA_SLOW_LO 6
`define FWA_SLOW_MAX 4'hA
`define FWA_RESP_OKAY 2'h0
`define FWA_RESP_SLVERR 2'h2
`endif

// >>> rtl/fwa_pkg.sv
// types shared by the field-weakening config bank
`default_nettype none
package fwa_pkg;
  // control mode, as the mode pins encode it
  typedef enum logic [1:0] {FWA_SPEED, FWA_POWER, FWA_TORQUE, FWA_DUTY} fwa_mode_t;
  // register image, msb first
  typedef struct packed {
    logic parity;
    logic [9:0] fw_prop_gain;
    logic [9:0] current_loop_int_gain;
    logic fw_enable;
    logic [3:0] closed_loop_slow_accel;
    logic [5:0] unused;
  } fwa_cfg_t;
  // decoded gains: kp times 10000, ki times 1000, both exact integers
  typedef struct packed {
    logic [17:0] kp_x10k;
    logic [21:0] ki_x1k;
  } fwa_gain_t;
endpackage : fwa_pkg
`default_nettype wire

// >>> verification/test_field_weakening_accel_config.sv
// self-checking testbench for the field-weakening config bank
`include "fwa_defs.svh"
`default_nettype none
module test_field_weakening_accel_config
  import fwa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals and device
  // ----------------------------------------
  localparam logic [11:0] A_CFG = {`FWA_IDX_ALGO2, 2'b00};
  localparam logic [11:0] A_STAT = {`FWA_IDX_STATUS, 2'b00};
  int kpm[4] = '{1000, 100, 10, 1};
  int kim[4] = '{10000, 1000, 100, 10};
  int rt[16] = '{1, 10, 20, 30, 50, 100, 200, 300, 400, 500, 1000, 0, 0, 0, 0, 0};
  // write data beside the word that should read back
  logic [63:0] rows[4] = '{64'hFFFF_FFFF_FFFF_FFC0, 64'h8020_053F_8020_0500,
                           64'h3FF4_0295_3FF4_0280, 64'h40B8_7ACA_40B8_7AC0};
  int n_errors = 0;
  int tests_run = 0;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] ctrl_mode = 2'h0;
  logic limit_active = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fw_en, acc_valid, align_act, limit_ramp;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [10:0] acc_rate;
  fwa_gain_t gains;
  fwa_mode_t rate_unit;
  logic [31:0] d;
  logic [1:0] r;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  fwa_config_bank i_dut (
    .CLK(clk), .SYS_RST(sys_rst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CTRL_MODE(ctrl_mode), .LIMIT_ACTIVE(limit_active),
    .GAINS(gains), .FW_ENABLE(fw_en), .SLOW_ACCEL_RATE(acc_rate),
    .SLOW_ACCEL_VALID(acc_valid), .ALIGN_ACCEL_ACTIVE(align_act),
    .LIMIT_RAMP_ACTIVE(limit_ramp), .RATE_UNIT(rate_unit)
  );

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: value %0h, expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: response %0h, expected %0h", $time, got, exp);
    end
  endtask

  // each half is released on its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] rs);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // decoded outputs against a register image
  task automatic chk_dec(input logic [31:0] v);
    chk(gains.kp_x10k, 64'(v[28:21] * kpm[v[30:29]]));
    chk(gains.ki_x1k, 64'(v[18:11] * kim[v[20:19]]));
    chk(fw_en, v[10]);
    chk(acc_rate, 64'(rt[v[9:6]]));
    chk(acc_valid, v[9:6] <= `FWA_SLOW_MAX);
  endtask

  task automatic end_sim;
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_dec(32'h0);
    rd(A_CFG, d, r);
    chk(d, `FWA_ALGO2_RST);
    chk_rsp(r, `FWA_RESP_OKAY);
    // table rows
    for (int i = 0; i < 4; i++) begin
      wr(A_CFG, rows[i][63:32], 4'hF, r);
      chk_rsp(r, `FWA_RESP_OKAY);
      rd(A_CFG, d, r);
      chk(d, rows[i][31:0]);
      chk_dec(rows[i][31:0]);
    end
    // every acceleration code, including the undefined ones
    for (int c = 0; c < 16; c++) begin
      wr(A_CFG, 32'(c << 6), 4'hF, r);
      chk_dec(32'(c << 6));
    end
    // byte strobe merges only byte one
    wr(A_CFG, 32'h0, 4'hF, r);
    wr(A_CFG, 32'hFFFF_FFFF, 4'h2, r);
    rd(A_CFG, d, r);
    chk(d, 32'h0000_FF00);
    // unmapped place refused, register untouched
    wr(12'h000, 32'hFFFF_FFFF, 4'hF, r);
    chk_rsp(r, `FWA_RESP_SLVERR);
    rd(A_CFG, d, r);
    chk(d, 32'h0000_FF00);
    rd(12'h000, d, r);
    chk(d, 32'h0);
    chk_rsp(r, `FWA_RESP_SLVERR);
    wr(A_STAT, 32'hFFFF_FFFF, 4'hF, r);
    chk_rsp(r, `FWA_RESP_OKAY);
    // every control mode, limit toggling
    for (int m = 0; m < 4; m++) begin
      ctrl_mode <= 2'(m);
      limit_active <= m[0];
      repeat (4) @(posedge clk);
      chk(rate_unit, 64'(m));
      chk(align_act, m == 0);
      chk(limit_ramp, m[0]);
      rd(A_STAT, d, r);
      chk(d, {29'h0, m[0], m[1:0]});
    end
    // reset in mid-run clears everything
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_dec(32'h0);
    rd(A_CFG, d, r);
    chk(d, 32'h0);
    end_sim;
  end

  // watchdog, far beyond the expected run
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
endmodule // test_field_weakening_accel_config
`default_nettype wire
